//--- logic/uart_tmo_baud.sv
// uart time-out, fractional baud generator and dma ready pins, two channels
`timescale 1ns/10ps
// What this block does
// - thr-empty flag set at reset, interrupt raised once enable bit 1 is set
// - ident shows only highest pending source
// - rx data and time-out share enable bit
// - rx interrupt at fifo trigger level
// - no time-out while rx fifo empty
// - time-out restarts at stop centre, rhr read
// - time-out after four character times
// - integer divisor one to 65535
// - fractional part extends the divisor
// - modem control bit 7 picks prescaler
// - sample clock sixteen per bit
// - one baud tick for tx and rx
// - fifo control bit 3 selects dma
// - non-dma rx ready high when empty
// - dma rx ready low at trigger/timeout
// - non-dma tx ready high when not empty
// - dma tx ready high when full
// - fifo full at 32, else 128
// - any level register selects extended mode; a nonzero rx level gives the rx trigger
module uart_tmo_baud
  import uart_tmo_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHANNELS
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [CHANNELS-1:0] rx_ready_pin,
  output logic      [CHANNELS-1:0] tx_ready_pin,
  output logic      [CHANNELS-1:0] baud_tick,
  output logic      [CHANNELS-1:0] int_pending
);

  // character length in bit times, doubled so 1.5 stop bits stays integral
  function automatic logic [4:0] half_bits(input logic [7:0] lcr);
    logic [4:0] n;
    n = 5'd2 + 5'((5 + lcr[1:0]) * 2) + (lcr[3] ? 5'd2 : 5'd0);
    if (!lcr[2])
      n = n + 5'd2;
    else if (lcr[1:0] == 2'b00)
      n = n + 5'd3;
    else
      n = n + 5'd4;
    return n;
  endfunction

  // ceil(16*(n + m/16)) = 16*n + m, times the prescaler
  function automatic logic [21:0] period(input logic [15:0] n,
                                         input logic [3:0]  m,
                                         input logic        slow);
    logic [21:0] p;
    // a zero integer part would stall the divider, so it runs as one
    p = {2'b00, (n == 16'h0) ? 16'h0001 : n, 4'h0} + {18'h0, m};
    return slow ? 22'(p * PRESC_SLOW) : p;
  endfunction

  // address phase capture
  bus_req_t   req;
  logic       req_valid;
  wire        addr_take = hsel && htrans[1] && hready;
  always_ff @(posedge clk) begin
    if (rst) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else if (hready) begin
      req_valid <= addr_take;
      req       <= '{write: hwrite, addr: haddr[7:0]};
    end
  end

  wire       wr_en = req_valid && req.write;
  wire       rd_en = req_valid && !req.write;
  wire [7:0] wr_val = hwdata[7:0];

  logic [31:0] rd_mux [CHANNELS];

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    localparam logic [7:0] BASE = 8'(c * CH_STRIDE);
    chan_cfg_t   cfg;
    logic [7:0]  rx_count;
    logic [7:0]  tx_count;
    logic        thr_flag;
    logic        tmo_flag;
    logic        rx_dma_low;
    logic        tx_dma_high;
    logic [21:0] div_cnt;
    logic [21:0] tmo_cnt;
    logic [7:0]  ident;

    wire [7:0] off   = req.addr - BASE;
    wire       mine  = req.addr >= BASE && req.addr < 8'(BASE + CH_STRIDE);
    wire       w_ier = wr_en && mine && off == OFF_INT_ENABLE;
    wire       w_ev  = wr_en && mine && off == OFF_FIFO_EVENT;
    wire       r_rhr = rd_en && mine && off == OFF_RX_HOLDING;
    wire       r_isr = rd_en && mine && off == OFF_INT_IDENT;

    wire ev_stop = w_ev && wr_val[EV_STOP_BIT];
    wire ev_rxp  = w_ev && wr_val[EV_RX_PUSH_BIT];
    wire ev_txp  = w_ev && wr_val[EV_TX_PUSH_BIT];
    wire ev_txo  = w_ev && wr_val[EV_TX_POP_BIT];

    wire extended = |{cfg.txl, cfg.rxl, cfg.fhi, cfg.flo};
    wire [7:0] cap = extended ? FIFO_EXTENDED : FIFO_NORMAL;
    wire [1:0] fsel = cfg.fifo_ctrl_reg[7:6];
    wire [7:0] legacy_trig = fsel == 2'd0 ? 8'd8 : fsel == 2'd1 ? 8'd16 :
                             fsel == 2'd2 ? 8'd24 : 8'd28;
    wire [7:0] rx_trig = (extended && cfg.rxl != 8'h00) ? cfg.rxl
                                                        : legacy_trig;
    wire rx_full  = rx_count >= cap;
    wire tx_full  = tx_count >= cap;
    wire rx_empty = rx_count == 8'h00;
    wire rx_at_trig = rx_count >= rx_trig;

    wire rx_pop = r_rhr && !rx_empty;
    wire dma    = cfg.fifo_ctrl_reg[FC_DMA_BIT];

    // one divider per channel; its tick times both directions
    wire [21:0] per = period({cfg.dlh, cfg.dll}, cfg.frac[3:0],
                             cfg.modem_ctrl_reg[MC_PRESC_BIT]);
    wire tick = div_cnt == 22'h0;
    wire [21:0] tmo_limit =
      22'(half_bits(cfg.lcr) * SAMPLES_PER_BIT * TMO_CHARS / 2);

    // priority encoder: only the top pending source is shown
    wire rx_src  = cfg.interrupt_enable_reg[IE_RX_BIT] && rx_at_trig;
    wire tmo_src = cfg.interrupt_enable_reg[IE_RX_BIT] && tmo_flag;
    wire thr_src = cfg.interrupt_enable_reg[IE_THR_BIT] && thr_flag;
    wire [3:0] top = tmo_src ? ID_RX_TMO : rx_src ? ID_RX_DATA :
                     thr_src ? ID_THR : ID_NONE;

    always_ff @(posedge clk) begin
      if (rst) begin
        cfg <= '{interrupt_enable_reg: RST_IER, fifo_ctrl_reg: RST_FCR, lcr: RST_LCR, modem_ctrl_reg: RST_MCR,
                 dll: RST_DLL, dlh: RST_DLH, frac: RST_FRAC, txl: RST_LVL,
                 rxl: RST_LVL, fhi: RST_LVL, flo: RST_LVL};
      end else if (wr_en && mine) begin
        unique case (off)
          OFF_INT_ENABLE: cfg.interrupt_enable_reg  <= wr_val;
          OFF_FIFO_CTRL:  cfg.fifo_ctrl_reg  <= wr_val;
          OFF_LINE_CTRL:  cfg.lcr  <= wr_val;
          OFF_MODEM_CTRL: cfg.modem_ctrl_reg  <= wr_val;
          OFF_DIV_LOW:    cfg.dll  <= wr_val;
          OFF_DIV_HIGH:   cfg.dlh  <= wr_val;
          OFF_FRAC_DIV:   cfg.frac <= wr_val;
          OFF_TX_LEVEL:   cfg.txl  <= wr_val;
          OFF_RX_LEVEL:   cfg.rxl  <= wr_val;
          OFF_FLOW_HIGH:  cfg.fhi  <= wr_val;
          OFF_FLOW_LOW:   cfg.flo  <= wr_val;
          default: ;
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        rx_count <= 8'h00;
        tx_count <= 8'h00;
      end else begin
        rx_count <= 8'(rx_count + (ev_rxp && !rx_full) - rx_pop);
        tx_count <= 8'(tx_count + (ev_txp && !tx_full)
                    - (ev_txo && tx_count != 8'h00));
      end
    end

    // thr flag set at reset so enabling bit 1 raises it at once
    always_ff @(posedge clk) begin
      if (rst)
        thr_flag <= 1'b1;
      else if (ev_txo && tx_count == 8'd1)
        thr_flag <= 1'b1;
      else if (r_isr && top == ID_THR || ev_txp)
        thr_flag <= 1'b0;
    end

    always_ff @(posedge clk) begin
      if (rst)
        div_cnt <= 22'h0;
      else if (tick)
        div_cnt <= 22'(per - 22'd1);
      else
        div_cnt <= 22'(div_cnt - 22'd1);
    end

    // time-out counts baud ticks; a restart event overrides expiry
    always_ff @(posedge clk) begin
      if (rst) begin
        tmo_cnt  <= 22'h0;
        tmo_flag <= 1'b0;
      end else if (ev_stop || rx_pop) begin
        tmo_cnt  <= 22'h0;
        tmo_flag <= 1'b0;
      end else if (rx_empty) begin
        tmo_cnt  <= 22'h0;
        tmo_flag <= 1'b0;
      end else if (tick && !tmo_flag) begin
        if (tmo_cnt + 22'd1 >= tmo_limit)
          tmo_flag <= 1'b1;
        tmo_cnt <= 22'(tmo_cnt + 22'd1);
      end
    end

    // dma rx ready holds its level between set and clear; dma tx ready follows tx_full each cycle
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_dma_low  <= 1'b0;
        tx_dma_high <= 1'b0;
      end else begin
        if (rx_empty)
          rx_dma_low <= 1'b0;
        else if (rx_at_trig || tmo_flag)
          rx_dma_low <= 1'b1;
        if (tx_full)
          tx_dma_high <= 1'b1;
        else
          tx_dma_high <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        rx_ready_pin[c] <= 1'b1;
        tx_ready_pin[c] <= 1'b0;
        baud_tick[c]    <= 1'b0;
        int_pending[c]  <= 1'b0;
      end else begin
        rx_ready_pin[c] <= dma ? !rx_dma_low : rx_empty;
        tx_ready_pin[c] <= dma ? tx_dma_high : tx_count != 8'h00;
        baud_tick[c]    <= tick;
        int_pending[c]  <= top != ID_NONE;
      end
    end

    assign ident = {4'h0, top};
    wire [7:0] line_state_reg = {2'b00, tx_count == 8'h00, 4'h0, !rx_empty};
    always_comb begin
      rd_mux[c] = BUS_OKAY_DATA;
      if (mine) begin
        unique case (off)
          OFF_INT_ENABLE:  rd_mux[c] = {24'h0, cfg.interrupt_enable_reg};
          OFF_INT_IDENT:   rd_mux[c] = {24'h0, ident};
          OFF_FIFO_CTRL:   rd_mux[c] = {24'h0, cfg.fifo_ctrl_reg};
          OFF_LINE_CTRL:   rd_mux[c] = {24'h0, cfg.lcr};
          OFF_MODEM_CTRL:  rd_mux[c] = {24'h0, cfg.modem_ctrl_reg};
          OFF_LINE_STATE:  rd_mux[c] = {24'h0, line_state_reg};
          OFF_DIV_LOW:     rd_mux[c] = {24'h0, cfg.dll};
          OFF_DIV_HIGH:    rd_mux[c] = {24'h0, cfg.dlh};
          OFF_FRAC_DIV:    rd_mux[c] = {24'h0, cfg.frac};
          OFF_TX_LEVEL:    rd_mux[c] = {24'h0, cfg.txl};
          OFF_RX_LEVEL:    rd_mux[c] = {24'h0, cfg.rxl};
          OFF_FLOW_HIGH:   rd_mux[c] = {24'h0, cfg.fhi};
          OFF_FLOW_LOW:    rd_mux[c] = {24'h0, cfg.flo};
          OFF_FIFO_STATUS: rd_mux[c] = {16'h0, tx_count, rx_count};
          default:         rd_mux[c] = BUS_OKAY_DATA;
        endcase
      end
    end
  end

  logic [31:0] rd_or;
  always_comb begin
    rd_or = BUS_OKAY_DATA;
    for (int i = 0; i < CHANNELS; i++)
      rd_or = rd_or | rd_mux[i];
  end

  // zero-wait slave: data phase completes in one cycle, always okay
  assign hrdata    = rd_en ? rd_or : BUS_OKAY_DATA;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // uart_tmo_baud

//--- logic/uart_tmo_pkg.sv
// package: register map, field positions and timing constants for the uart block
package uart_tmo_pkg;
  localparam int unsigned NUM_CHANNELS = 2;
  localparam logic [7:0] CH_STRIDE = 8'h40;
  // per-channel word offsets (byte addresses)
  localparam logic [7:0] OFF_RX_HOLDING   = 8'h00;
  localparam logic [7:0] OFF_INT_ENABLE   = 8'h04;
  localparam logic [7:0] OFF_INT_IDENT    = 8'h08;
  localparam logic [7:0] OFF_FIFO_CTRL    = 8'h0C;
  localparam logic [7:0] OFF_LINE_CTRL    = 8'h10;
  localparam logic [7:0] OFF_MODEM_CTRL   = 8'h14;
  localparam logic [7:0] OFF_LINE_STATE   = 8'h18;
  localparam logic [7:0] OFF_DIV_LOW      = 8'h1C;
  localparam logic [7:0] OFF_DIV_HIGH     = 8'h20;
  localparam logic [7:0] OFF_FRAC_DIV     = 8'h24;
  localparam logic [7:0] OFF_TX_LEVEL     = 8'h28;
  localparam logic [7:0] OFF_RX_LEVEL     = 8'h2C;
  localparam logic [7:0] OFF_FLOW_HIGH    = 8'h30;
  localparam logic [7:0] OFF_FLOW_LOW     = 8'h34;
  localparam logic [7:0] OFF_FIFO_STATUS  = 8'h38;
  localparam logic [7:0] OFF_FIFO_EVENT   = 8'h3C;
  // field positions
  localparam int unsigned IE_RX_BIT      = 0;
  localparam int unsigned IE_THR_BIT     = 1;
  localparam int unsigned FC_DMA_BIT     = 3;
  localparam int unsigned MC_PRESC_BIT   = 7;
  localparam int unsigned LS_DR_BIT      = 0;
  localparam int unsigned LS_THRE_BIT    = 5;
  // event register bits: writes of 1 report a stop-bit centre, rx push, tx push, tx pop
  localparam int unsigned EV_STOP_BIT    = 0;
  localparam int unsigned EV_RX_PUSH_BIT = 1;
  localparam int unsigned EV_TX_PUSH_BIT = 2;
  localparam int unsigned EV_TX_POP_BIT  = 3;
  // reset values
  localparam logic [7:0] RST_IER  = 8'h00;
  localparam logic [7:0] RST_FCR  = 8'h00;
  localparam logic [7:0] RST_LCR  = 8'h03;
  localparam logic [7:0] RST_MCR  = 8'h00;
  localparam logic [7:0] RST_DLL  = 8'h01;
  localparam logic [7:0] RST_DLH  = 8'h00;
  localparam logic [7:0] RST_FRAC = 8'h00;
  localparam logic [7:0] RST_LVL  = 8'h00;
  // interrupt identification codes; priority is time-out, rx data, then thr
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [3:0] ID_RX_DATA = 4'h4;
  localparam logic [3:0] ID_RX_TMO  = 4'hC;
  localparam logic [3:0] ID_THR     = 4'h2;
  // fifo sizes and timing
  localparam logic [7:0] FIFO_NORMAL   = 8'd32;
  localparam logic [7:0] FIFO_EXTENDED = 8'd128;
  localparam int unsigned TMO_CHARS    = 4;
  localparam int unsigned SAMPLES_PER_BIT = 16;
  localparam int unsigned PRESC_SLOW   = 4;
  localparam logic [31:0] BUS_OKAY_DATA = 32'h0000_0000;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] interrupt_enable_reg;
    logic [7:0] fifo_ctrl_reg;
    logic [7:0] lcr;
    logic [7:0] modem_ctrl_reg;
    logic [7:0] dll;
    logic [7:0] dlh;
    logic [7:0] frac;
    logic [7:0] txl;
    logic [7:0] rxl;
    logic [7:0] fhi;
    logic [7:0] flo;
  } chan_cfg_t;
endpackage

//--- testbench/ahb_host_model.sv
// ahb-lite host model issuing single word transfers
`timescale 1ns/10ps
module ahb_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic [31:0] rd_q;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // capture at the edge itself so the slave's own flops cannot race it
  always_ff @(posedge clk) rd_q <= hrdata;
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    #1;
    q = rd_q;
  endtask
endmodule // ahb_host_model

//--- testbench/uart_tmo_baud_monitor.sv
// port assertions for the uart time-out and baud block
`timescale 1ns/10ps
module uart_tmo_baud_monitor
  import uart_tmo_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHANNELS
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [CHANNELS-1:0] rx_ready_pin,
  input wire logic [CHANNELS-1:0] tx_ready_pin,
  input wire logic [CHANNELS-1:0] baud_tick,
  input wire logic [CHANNELS-1:0] int_pending
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  logic ier_wr;
  wire  ier_hit = hsel & htrans[1] & hready & hwrite
                  & (haddr == 32'(OFF_INT_ENABLE));
  always_ff @(posedge clk) begin
    ier_wr <= rst ? 1'b0 : ier_hit;
  end
  a_slave_ready: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("response not okay");
  a_rst_rx_high:
    assert property (disable iff (1'b0) rst |=> rx_ready_pin == '1)
      else $error("rx ready not high after reset");
  a_rst_tx_low:
    assert property (disable iff (1'b0) rst |=> tx_ready_pin == '0)
      else $error("tx ready not low after reset");
  a_rst_no_int:
    assert property (disable iff (1'b0) rst |=> int_pending == '0)
      else $error("interrupt pending after reset");
  a_tick_single:
    assert property (baud_tick[1] |=> !baud_tick[1])
      else $error("baud tick longer than one cycle");
  a_tick_spacing:
    assert property (baud_tick[0] |=> (!baud_tick[0]) [*8])
      else $error("baud ticks too close");
  a_ier_clear:
    assert property (ier_wr && hwdata[1:0] == 2'b00 |-> ##2 !int_pending[0])
      else $error("interrupt pending with sources disabled");
  c_tick: cover property (baud_tick[1]);
  c_int: cover property ($rose(int_pending[0]));
  c_rx_low: cover property ($fell(rx_ready_pin[0]));
  c_tx_high: cover property ($rose(tx_ready_pin[0]));
endmodule // uart_tmo_baud_monitor

bind uart_tmo_baud uart_tmo_baud_monitor #(.CHANNELS(CHANNELS)) u_mon (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rx_ready_pin(rx_ready_pin), .tx_ready_pin(tx_ready_pin),
  .baud_tick(baud_tick), .int_pending(int_pending));

//--- testbench/uart_tmo_baud_tb.sv
// self-checking bench for the uart time-out, baud and ready pin block
`timescale 1ns/10ps
module uart_tmo_baud_tb
  import uart_tmo_pkg::*;
;
  // 8n1 frame is ten bits; divisor one gives 16 clocks per tick
  localparam int TMO = TMO_CHARS * 10 * SAMPLES_PER_BIT * 16;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  rx_ready_pin;
  logic [1:0]  tx_ready_pin;
  logic [1:0]  baud_tick;
  logic [1:0]  int_pending;
  logic [31:0] q;
  int          n_mismatch;
  int          num_checks;

  uart_tmo_baud u_uart_tmo_baud (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_ready_pin(rx_ready_pin),
    .tx_ready_pin(tx_ready_pin), .baud_tick(baud_tick),
    .int_pending(int_pending));
  ahb_host_model u_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input int ch, input logic [7:0] o, input logic [7:0] d);
    u_host.xfer(1'b1, CH_STRIDE * 8'(ch) + o, {24'h0, d}, q);
  endtask
  task automatic rd(input int ch, input logic [7:0] o);
    u_host.xfer(1'b0, CH_STRIDE * 8'(ch) + o, 32'h0, q);
  endtask
  task automatic ident(input string nm, input logic [3:0] e);
    rd(0, OFF_INT_IDENT);
    chk(nm, 32'(e), 32'(q[3:0]));
  endtask
  task automatic t_reset;
    chk("rx_rdy_rst", 32'h3, 32'(rx_ready_pin));
    chk("tx_rdy_rst", 32'h0, 32'(tx_ready_pin));
    wr(2, OFF_INT_ENABLE, 8'hFF);
    rd(2, OFF_INT_ENABLE);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_prio;
    wr(0, OFF_INT_ENABLE, 8'h03);
    cyc(1);
    chk("int_thr", 32'h1, 32'(int_pending[0]));
    chk("int_b", 32'h0, 32'(int_pending[1]));
    for (int i = 0; i < 8; i++) wr(0, OFF_FIFO_EVENT, 8'h02);
    cyc(2);
    chk("rx_rdy_data", 32'h0, 32'(rx_ready_pin[0]));
    ident("id_rx", ID_RX_DATA);
    rd(0, OFF_RX_HOLDING);
    ident("id_thr", ID_THR);
    rd(0, OFF_LINE_STATE);
    chk("data_ready", 32'h1, 32'(q[LS_DR_BIT]));
    for (int i = 0; i < 7; i++) rd(0, OFF_RX_HOLDING);
    cyc(2);
    chk("rx_rdy_empty", 32'h1, 32'(rx_ready_pin[0]));
    ident("id_none", ID_NONE);
  endtask
  task automatic t_timeout;
    wr(0, OFF_FIFO_CTRL, 8'h08);
    wr(0, OFF_FIFO_EVENT, 8'h03);
    cyc(2);
    chk("dma_rx_below", 32'h1, 32'(rx_ready_pin[0]));
    cyc(5000);
    wr(0, OFF_FIFO_EVENT, 8'h01);
    cyc(TMO - 200);
    ident("tmo_early", ID_NONE);
    cyc(400);
    ident("tmo_due", ID_RX_TMO);
    chk("dma_rx_tmo", 32'h0, 32'(rx_ready_pin[0]));
    rd(0, OFF_RX_HOLDING);
    cyc(TMO + 400);
    ident("tmo_empty", ID_NONE);
    chk("dma_rx_empty", 32'h1, 32'(rx_ready_pin[0]));
  endtask
  task automatic t_tx_norm;
    wr(0, OFF_FIFO_CTRL, 8'h00);
    wr(0, OFF_FIFO_EVENT, 8'h04);
    cyc(2);
    chk("tx_rdy_one", 32'h1, 32'(tx_ready_pin[0]));
    wr(0, OFF_FIFO_EVENT, 8'h08);
    cyc(2);
    chk("tx_rdy_none", 32'h0, 32'(tx_ready_pin[0]));
  endtask
  task automatic t_fill(input int depth);
    wr(0, OFF_FIFO_CTRL, 8'h08);
    for (int i = 1; i < depth; i++) wr(0, OFF_FIFO_EVENT, 8'h04);
    cyc(2);
    chk("tx_rdy_part", 32'h0, 32'(tx_ready_pin[0]));
    wr(0, OFF_FIFO_EVENT, 8'h04);
    cyc(2);
    chk("tx_rdy_full", 32'h1, 32'(tx_ready_pin[0]));
    wr(0, OFF_FIFO_EVENT, 8'h08);
    cyc(2);
    chk("tx_rdy_free", 32'h0, 32'(tx_ready_pin[0]));
    for (int i = 1; i < depth; i++) wr(0, OFF_FIFO_EVENT, 8'h08);
  endtask
  task automatic t_ext;
    wr(0, OFF_TX_LEVEL, 8'h01);
    wr(0, OFF_RX_LEVEL, 8'h02);
    t_fill(128);
    wr(0, OFF_FIFO_EVENT, 8'h02);
    wr(0, OFF_FIFO_EVENT, 8'h02);
    ident("id_ext_trig", ID_RX_DATA);
    wr(0, OFF_INT_ENABLE, 8'h00);
    cyc(3);
    chk("int_off", 32'h0, 32'(int_pending[0]));
  endtask
  task automatic per(input int ch, output int n);
    while (baud_tick[ch] !== 1'b1) cyc(1);
    cyc(1);
    n = 1;
    while (baud_tick[ch] !== 1'b1) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_baud;
    int n;
    wr(1, OFF_DIV_LOW, 8'h03);
    wr(1, OFF_FRAC_DIV, 8'h04);
    wr(1, OFF_MODEM_CTRL, 8'h80);
    wr(0, OFF_DIV_HIGH, 8'h01);
    wr(0, OFF_DIV_LOW, 8'h00);
    per(1, n);
    per(1, n);
    chk("period_b", 32'd208, 32'(n));
    per(0, n);
    per(0, n);
    chk("period_a", 32'd4096, 32'(n));
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    t_reset;
    t_prio;
    t_timeout;
    t_tx_norm;
    t_fill(32);
    t_ext;
    t_baud;
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule // uart_tmo_baud_tb
